// ==== inc/secr_defs.svh ====
// Purpose: Constants for the switch element cell routing block.
// Assumes: Eight element ports, three-bit rows in the internal address.
// Notes:   Included by bare name; definitions only.
`ifndef SECR_DEFS_SVH
`define SECR_DEFS_SVH

`define SECR_ROW_W       3
`define SECR_ROWS        9
`define SECR_CODE_W      3
`define SECR_CFG_W       2
`define SECR_RC_PATH     3'h0
`define SECR_RC_RAND     3'h2
`define SECR_CFG_INS3    2'h3
`define SECR_CFG_INS2    2'h2
`define SECR_CFG_NONE    2'h0
`define SECR_CNT_RST     3'h0
`define SECR_FIFO_DEPTH  4

`endif

// ==== inc/secr_pkg.sv ====
// Purpose: Types for the switch element cell routing block.
// Assumes: Constants live in secr_defs.svh.
// Notes:   Output stage state is one-hot.
package secr_pkg;
   typedef logic [2:0] secr_port_t;
   typedef enum logic [1:0] {
      secr_idle = 2'b01,
      secr_full = 2'b10
   } secr_ost_t;
endpackage

// ==== design/secr_route.sv ====
// Purpose: Routing decision and header modification of one switch element.
// Assumes: Cell header words arrive with valid/ready; cell_time_i pulses once per cell time.
// Notes:   A four-word FIFO sits between the arriving header and the routing stage.
`timescale 1ns/1ps
`include "secr_defs.svh"

module secr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `SECR_FIFO_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r   [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    wp_nxt;
   logic [AW-1:0]    rp_r;
   logic [AW-1:0]    rp_nxt;
   logic [CW-1:0]    cnt_r;
   logic [CW-1:0]    cnt_nxt;
   logic             rdy_r;
   logic             rdy_nxt;
   logic             vld_r;
   logic             vld_nxt;
   logic             wr;
   logic             rd;

   // Ready and valid come from flops so neither side sees a combinational path
   assign wr          = in_valid_i && rdy_r;
   assign rd          = vld_r && out_ready_i;
   assign in_ready_o  = rdy_r;
   assign out_valid_o = vld_r;
   assign out_data_o  = mem_r[rp_r];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_ent
         always_comb begin
            mem_nxt[g] = (wr && wp_r == AW'(g)) ? in_data_i : mem_r[g];
         end
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               mem_r[g] <= '0;
            end else begin
               mem_r[g] <= mem_nxt[g];
            end
         end
      end
   endgenerate

   always_comb begin
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (wr) begin
         wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : AW'(wp_r + 1'b1);
      end
      if (rd) begin
         rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : AW'(rp_r + 1'b1);
      end
      if (wr && !rd) begin
         cnt_nxt = CW'(cnt_r + 1'b1);
      end else if (rd && !wr) begin
         cnt_nxt = CW'(cnt_r - 1'b1);
      end
      rdy_nxt = (cnt_nxt != CW'(DEPTH));
      vld_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         rdy_r <= 1'b1;
         vld_r <= 1'b0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         rdy_r <= rdy_nxt;
         vld_r <= vld_nxt;
      end
   end
endmodule

module secr_route #(
   parameter int ROWS  = `SECR_ROWS,
   parameter int DEPTH = `SECR_FIFO_DEPTH
) (
   input  wire logic                        clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        cell_time_i,
   input  wire logic [`SECR_CFG_W-1:0]      stage_random_bit_config_i,
   input  wire logic                        cell_valid_i,
   output logic                             cell_ready_o,
   input  wire logic [2:0]                  in_port_i,
   input  wire logic [`SECR_CODE_W-1:0]     routing_control_code_i,
   input  wire logic [ROWS*`SECR_ROW_W-1:0] internal_route_address_i,
   output logic                             out_valid_o,
   input  wire logic                        out_ready_i,
   output logic      [2:0]                  out_port_o,
   output logic      [`SECR_CODE_W-1:0]     routing_control_code_o,
   output logic      [ROWS*`SECR_ROW_W-1:0] internal_route_address_o
);
   localparam int RW = `SECR_ROW_W;
   localparam int AW = ROWS * RW;
   localparam int FW = 3 + `SECR_CODE_W + AW;

   logic [FW-1:0]                f_data;
   logic                         f_valid;
   logic                         take;
   secr_pkg::secr_port_t         f_port;
   logic [`SECR_CODE_W-1:0]      f_code;
   logic [AW-1:0]                f_addr;
   logic [RW-1:0]                top_row;
   logic [2:0]                   rnd;
   logic [2:0]                   cnt_r;
   logic [2:0]                   cnt_nxt;
   logic [AW+RW-1:0]             down3;
   logic [AW-1:0]                ins2;
   secr_pkg::secr_port_t         port_nxt;
   logic [AW-1:0]                addr_nxt;
   secr_pkg::secr_ost_t          st_r;
   secr_pkg::secr_ost_t          st_nxt;
   logic                         vld_r;
   logic                         vld_nxt;
   secr_pkg::secr_port_t         port_r;
   logic [`SECR_CODE_W-1:0]      code_r;
   logic [`SECR_CODE_W-1:0]      code_nxt;
   logic [AW-1:0]                addr_r;
   logic [AW-1:0]                addr_hold;

   secr_fifo #(
      .WIDTH (FW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (cell_valid_i),
      .in_ready_o  (cell_ready_o),
      .in_data_i   ({in_port_i, routing_control_code_i, internal_route_address_i}),
      .out_valid_o (f_valid),
      .out_ready_i (take),
      .out_data_o  (f_data)
   );

   assign f_port  = f_data[FW-1 -: 3];
   assign f_code  = f_data[AW +: `SECR_CODE_W];
   assign f_addr  = f_data[AW-1:0];
   assign top_row = f_addr[AW-1 -: RW];

   // A stalled output stage holds the FIFO, which in turn drops cell_ready_o
   assign take = f_valid && (st_r == secr_pkg::secr_idle || out_ready_i);

   // Running counter, stepped by the cell time enable
   always_comb begin
      cnt_nxt = cell_time_i ? 3'(cnt_r + 3'h1) : cnt_r;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= `SECR_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Sum kept to three bits, so the carry falls away
   assign rnd   = 3'(cnt_r + f_port);
   assign down3 = {rnd, f_addr};
   // Two random bits replace the leading bits of the top two rows
   assign ins2  = {rnd[1:0], f_addr[AW-3], rnd[1:0], f_addr[AW-RW-3:0]};

   always_comb begin
      port_nxt = top_row;
      addr_nxt = {f_addr[AW-RW-1:0], {RW{1'b0}}};
      case (f_code)
         `SECR_RC_PATH: begin
            // Option pins play no part for path cells
            port_nxt = top_row;
            addr_nxt = {f_addr[AW-RW-1:0], {RW{1'b0}}};
         end
         `SECR_RC_RAND: begin
            case (stage_random_bit_config_i)
               `SECR_CFG_INS3: begin
                  port_nxt = down3[AW+RW-1 -: RW];
                  // Shifting back up restores the arriving rows
                  addr_nxt = down3[AW-1:0];
               end
               `SECR_CFG_INS2: begin
                  // Only the top row picks the port
                  port_nxt = ins2[AW-1 -: RW];
                  addr_nxt = {ins2[AW-2*RW-1:0], {2*RW{1'b0}}};
               end
               default: begin
                  // Unused code 01 is treated like the final stage
                  port_nxt = top_row;
                  addr_nxt = {f_addr[AW-2*RW-1:0], {2*RW{1'b0}}};
               end
            endcase
         end
         default: begin
            // Other codes follow the top row hop by hop
            port_nxt = top_row;
            addr_nxt = {f_addr[AW-RW-1:0], {RW{1'b0}}};
         end
      endcase
   end

   // Output stage: one header word held until the next stage takes it
   assign addr_hold = take ? addr_nxt : addr_r;

   always_comb begin
      st_nxt   = st_r;
      vld_nxt  = vld_r;
      code_nxt = take ? f_code : code_r;
      case (st_r)
         secr_pkg::secr_idle: begin
            if (take) begin
               st_nxt  = secr_pkg::secr_full;
               vld_nxt = 1'b1;
            end
         end
         secr_pkg::secr_full: begin
            if (out_ready_i && !take) begin
               st_nxt  = secr_pkg::secr_idle;
               vld_nxt = 1'b0;
            end
         end
         default: begin
            st_nxt  = secr_pkg::secr_idle;
            vld_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r   <= secr_pkg::secr_idle;
         vld_r  <= 1'b0;
         port_r <= '0;
         code_r <= '0;
         addr_r <= '0;
      end else begin
         st_r   <= st_nxt;
         vld_r  <= vld_nxt;
         port_r <= take ? port_nxt : port_r;
         code_r <= code_nxt;
         addr_r <= addr_hold;
      end
   end

   assign out_valid_o              = vld_r;
   assign out_port_o               = port_r;
   assign routing_control_code_o   = code_r;
   assign internal_route_address_o = addr_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence rand_take(logic [1:0] cfg);
      take && f_code == `SECR_RC_RAND && stage_random_bit_config_i == cfg;
   endsequence

   ins3_port_a: assert property (
      rand_take(`SECR_CFG_INS3) |=> out_port_o == 3'($past(cnt_r) + $past(f_port)) && out_valid_o)
      else $error("three-bit insertion picked the wrong port");

   rand_wrap_a: assert property (
      take && f_code == `SECR_RC_RAND && stage_random_bit_config_i == `SECR_CFG_INS3
      && (4'(cnt_r) + 4'(f_port)) > 4'h7
      |=> out_port_o == 3'($past(cnt_r) + $past(f_port) - 4'h8))
      else $error("random sum did not wrap modulo eight");

   ins3_restore_a: assert property (
      rand_take(`SECR_CFG_INS3) |=> internal_route_address_o == $past(f_addr))
      else $error("address not restored after three-bit insertion");

   ins2_port_a: assert property (
      rand_take(`SECR_CFG_INS2)
      |=> out_port_o == {$past(rnd[1:0]), $past(f_addr[AW-3])})
      else $error("two-bit insertion picked the wrong port");

   ins2_shift_a: assert property (
      rand_take(`SECR_CFG_INS2)
      |=> internal_route_address_o == {$past(f_addr[AW-2*RW-1:0]), {2*RW{1'b0}}})
      else $error("address not shifted two rows");

   final_stage_a: assert property (
      rand_take(`SECR_CFG_NONE)
      |=> out_port_o == $past(top_row)
          && internal_route_address_o == {$past(f_addr[AW-2*RW-1:0]), {2*RW{1'b0}}})
      else $error("final stage routing wrong");

   path_port_a: assert property (
      take && f_code == `SECR_RC_PATH |=> out_port_o == $past(top_row))
      else $error("path cell left on the wrong port");

   path_shift_a: assert property (
      take && f_code == `SECR_RC_PATH
      |=> internal_route_address_o == {$past(f_addr[AW-RW-1:0]), {RW{1'b0}}})
      else $error("path cell address not shifted one row");

   cnt_step_a: assert property (
      cell_time_i |=> cnt_r == 3'($past(cnt_r) + 3'h1))
      else $error("counter did not advance on cell time");

   out_hold_a: assert property (
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_port_o)
         && $stable(internal_route_address_o))
      else $error("output header changed while stalled");

   cov_ins3_c: cover property (rand_take(`SECR_CFG_INS3) ##1 out_valid_o);
   cov_ins2_c: cover property (rand_take(`SECR_CFG_INS2) ##1 out_valid_o);
   cov_path_c: cover property (take && f_code == `SECR_RC_PATH ##1 out_valid_o);
   cov_full_c: cover property (!cell_ready_o ##1 cell_ready_o);
endmodule

// ==== testbench/secr_sink.sv ====
// Purpose: Downstream partner that takes routed headers from the element.
// Assumes: Takes a header at a rising edge with valid and ready both high.
// Notes:   Stall holds ready low; slow mode gives ready every other cycle.
// Copy enable strapping is the board's job, no pin here.
`timescale 1ns/1ps
module secr_sink (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        stall_i,
   input  wire logic        slow_i,
   input  wire logic        valid_i,
   output logic             ready_o,
   input  wire logic [32:0] hdr_i,
   output logic             got_o,
   output logic      [32:0] got_hdr_o
);
   logic tog_r;
   assign ready_o = !stall_i && (!slow_i || tog_r);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tog_r     <= 1'b0;
         got_o     <= 1'b0;
         got_hdr_o <= 33'h0;
      end else begin
         tog_r <= !tog_r;
         got_o <= valid_i && ready_o;
         if (valid_i && ready_o) begin
            got_hdr_o <= hdr_i;
         end
      end
   end
endmodule

// ==== testbench/secr_route_tb.sv ====
// Purpose: Self-checking bench for the switch element routing block.
// Assumes: One header in flight for random rows, so the counter is known.
// Notes:   Expected headers queue up in offer order and pop as the sink takes them.
`timescale 1ns/1ps
`include "secr_defs.svh"
module secr_route_tb;
   typedef struct packed {
      logic [1:0]  cfg;
      logic [2:0]  code;
      logic [2:0]  inp;
      logic [2:0]  cnt;
      logic [26:0] addr;
   } secr_row_t;
   localparam secr_row_t ROWS [10] = '{
      '{2'h3, 3'h2, 3'h5, 3'h2, 27'h2c5a3b1}, '{2'h2, 3'h2, 3'h6, 3'h5, 27'h0a5b4c3},
      '{2'h0, 3'h2, 3'h7, 3'h5, 27'h2a43210}, '{2'h1, 3'h2, 3'h1, 3'h5, 27'h6b12345},
      '{2'h3, 3'h0, 3'h3, 3'h5, 27'h4123456}, '{2'h2, 3'h0, 3'h2, 3'h5, 27'h7654321},
      '{2'h0, 3'h0, 3'h0, 3'h5, 27'h0fedcba}, '{2'h3, 3'h2, 3'h7, 3'h7, 27'h3333333},
      '{2'h3, 3'h2, 3'h4, 3'h1, 27'h1555555}, '{2'h2, 3'h5, 3'h4, 3'h1, 27'h5a5a5a5}};
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        cell_time_i = 1'b0;
   logic [1:0]  stage_random_bit_config_i = 2'h0;
   logic        cell_valid_i = 1'b0;
   logic [2:0]  in_port_i = 3'h0;
   logic [2:0]  routing_control_code_i = 3'h0;
   logic [26:0] internal_route_address_i = 27'h0;
   logic        stall_r = 1'b0;
   logic        slow_r = 1'b0;
   wire         cell_ready_o;
   wire         out_valid_o;
   wire         out_ready_i;
   wire  [2:0]  out_port_o;
   wire  [2:0]  routing_control_code_o;
   wire  [26:0] internal_route_address_o;
   wire         got_o;
   wire  [32:0] got_hdr;
   logic [32:0] exp_q [$];
   logic [32:0] exp_h;
   logic [2:0]  cnt_m = 3'h0;
   int          n_errors = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          n_acc;
   bit          tk;
   secr_row_t   br;

   secr_route #(.ROWS(9), .DEPTH(4)) uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cell_time_i(cell_time_i),
      .stage_random_bit_config_i(stage_random_bit_config_i),
      .cell_valid_i(cell_valid_i), .cell_ready_o(cell_ready_o), .in_port_i(in_port_i),
      .routing_control_code_i(routing_control_code_i),
      .internal_route_address_i(internal_route_address_i), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .out_port_o(out_port_o),
      .routing_control_code_o(routing_control_code_o),
      .internal_route_address_o(internal_route_address_o));
   secr_sink sink (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .stall_i(stall_r), .slow_i(slow_r),
      .valid_i(out_valid_o), .ready_o(out_ready_i),
      .hdr_i({out_port_o, routing_control_code_o, internal_route_address_o}),
      .got_o(got_o), .got_hdr_o(got_hdr));

   always #50 clk_i = ~clk_i;

   // Own model of the routing decision, zero fill on every upward shift
   function automatic logic [32:0] expect_hdr(secr_row_t r);
      logic [2:0] rnd;
      logic [2:0] r0;
      rnd = 3'(r.cnt + r.inp);
      r0 = r.addr[26:24];
      if (r.code != `SECR_RC_RAND) return {r0, r.code, r.addr[23:0], 3'h0};
      if (r.cfg == `SECR_CFG_INS3) return {rnd, r.code, r.addr};
      if (r.cfg == `SECR_CFG_INS2) r0 = {rnd[1:0], r0[0]};
      return {r0, r.code, r.addr[20:0], 6'h0};
   endfunction

   task automatic chk(string name, logic [32:0] exp, logic [32:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict;
      $display("counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Entered just after a rising edge; returns just after the taking edge, or just after the last falling edge if the guard runs out
   task automatic send(secr_row_t r, int guard, output bit taken);
      taken = 1'b0;
      cell_valid_i <= 1'b1;
      stage_random_bit_config_i <= r.cfg;
      in_port_i <= r.inp;
      routing_control_code_i <= r.code;
      internal_route_address_i <= r.addr;
      repeat (guard) begin
         @(negedge clk_i);
         if (cell_ready_o === 1'b1) begin
            taken = 1'b1;
            break;
         end
      end
      if (taken) begin
         @(posedge clk_i);
         exp_q.push_back(expect_hdr(r));
      end
   endtask

   // Released port and address lines must not keep showing the last header
   task automatic rest;
      cell_valid_i <= 1'b0;
      internal_route_address_i <= ~internal_route_address_i;
      in_port_i <= ~in_port_i;
   endtask

   task automatic tick;
      @(posedge clk_i);
      cell_time_i <= 1'b1;
      @(posedge clk_i);
      cell_time_i <= 1'b0;
      cnt_m = cnt_m + 3'h1;
   endtask

   task automatic drain;
      repeat (300) begin
         @(negedge clk_i);
         if (exp_q.size() == 0) break;
      end
      chk("pending headers", 33'h0, 33'(exp_q.size()));
   endtask

   always @(negedge clk_i) begin
      if (got_o === 1'b1) begin
         exp_h = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
         chk("out_port_o", exp_h[32:30], got_hdr[32:30]);
         chk("routing_control_code_o", exp_h[29:27], got_hdr[29:27]);
         chk("internal_route_address_o", exp_h[26:0], got_hdr[26:0]);
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      chk("cell_ready_o in reset", 33'h1, cell_ready_o);
      chk("out_valid_o in reset", 33'h0, out_valid_o);
      chk("out_port_o in reset", 33'h0, out_port_o);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         while (cnt_m != ROWS[i].cnt) tick();
         @(posedge clk_i);
         slow_r <= i[0];
         send(ROWS[i], 50, tk);
         rest();
         drain();
         $display("test row %0d done", i);
      end
      // Sink stalls: four in the buffer plus one in the output stage, then refusal
      @(posedge clk_i);
      stall_r <= 1'b1;
      slow_r <= 1'b0;
      n_acc = 0;
      for (int k = 0; k < 6; k++) begin
         br = '{2'h2, 3'h0, 3'h1, 3'h0, {3'(k), 24'h6a5b4c}};
         send(br, 10, tk);
         if (!tk) break;
         n_acc++;
      end
      chk("headers accepted while stalled", 33'h5, 33'(n_acc));
      chk("cell_ready_o when full", 33'h0, cell_ready_o);
      @(posedge clk_i);
      stall_r <= 1'b0;
      slow_r <= 1'b1;
      send(br, 20, tk);
      rest();
      drain();
      $display("test full buffer done");
      // Reset in mid-run must clear the outputs and the routing counter
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      @(negedge clk_i);
      chk("cell_ready_o in mid reset", 33'h1, cell_ready_o);
      chk("out_valid_o in mid reset", 33'h0, out_valid_o);
      chk("out_port_o in mid reset", 33'h0, out_port_o);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      cnt_m = 3'h0;
      @(posedge clk_i);
      br = '{2'h3, 3'h2, 3'h3, 3'h0, 27'h1234567};
      send(br, 20, tk);
      rest();
      drain();
      $display("test mid reset done");
      print_verdict();
   end
endmodule
